// ---- common/pps_map.svh ----
/*
  Offsets, field positions, reset value and masks of the panel pin
  route register. Assumes inclusion by bare name from the design files.
*/
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

// -----------------------------------------------------------------
// Register map.
// -----------------------------------------------------------------
`define PPS_ROUTE_OFS 8'h00
`define PPS_ROUTE_RST 32'h0000_0000
`define PPS_ROUTE_MASK 32'h03ff_0fff
`define PPS_RSVD_HI_MSB 31
`define PPS_RSVD_HI_LSB 26
`define PPS_RSVD_MID_MSB 15
`define PPS_RSVD_MID_LSB 12

// -----------------------------------------------------------------
// Field positions, least significant bit of each 2-bit selector.
// -----------------------------------------------------------------
`define PPS_TSIG4_LSB 24
`define PPS_TSIG3_LSB 22
`define PPS_TSIG2_LSB 20
`define PPS_TSIG1_LSB 18
`define PPS_TSIG0_LSB 16
`define PPS_LSYNC_LSB 10
`define PPS_FSYNC_LSB 8
`define PPS_LATCH_LSB 6
`define PPS_DEN_LSB 4
`define PPS_DCLK_LSB 2
`define PPS_PWE_LSB 0
`define PPS_NUM_SIG 11

`endif

// ---- common/pps_pkg.sv ----
/*
  Types of the panel pin route block. Assumes the map header holds
  every number.
*/
package pps_pkg;

  // -----------------------------------------------------------------
  // Selector codes.
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_OFF = 2'h0,
    SEL_PIN0 = 2'h1,
    SEL_BAD2 = 2'h2,
    SEL_BAD3 = 2'h3
  } pps_sel_type;

  // -----------------------------------------------------------------
  // Register port request.
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pps_bus_type;

  // -----------------------------------------------------------------
  // Panel outputs of the display controller, bit 0 is write enable.
  // -----------------------------------------------------------------
  typedef struct packed {
    logic timing_sig4_out;
    logic timing_sig3_out;
    logic timing_sig2_out;
    logic timing_sig1_out;
    logic timing_sig0_out;
    logic line_sync_out;
    logic frame_sync_out;
    logic latch_enable_out;
    logic data_enable_out;
    logic dot_clock_out;
    logic write_enable_out;
  } pps_panel_type;

endpackage

// ---- logic/pps_route_reg.sv ----
/*
  Storage of the route register. Assumes the chip reset excludes the
  deep-standby transition reset, which never reaches this module.
*/
`timescale 1ns/10ps
`include "pps_map.svh"

module pps_route_reg (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] route_q
);

  logic [31:0] route_d;

  // -----------------------------------------------------------------
  // Store writes with the reserved bits dropped.
  // -----------------------------------------------------------------
  always_comb begin
    route_d = route_q;
    if (wr_en) begin
      route_d = wdata & `PPS_ROUTE_MASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      route_q <= `PPS_ROUTE_RST;
    end else begin
      route_q <= route_d;
    end
  end

endmodule

// ---- logic/pps_pin_cell.sv ----
/*
  One pin output stage. Assumes the default pin control and the panel
  signal are synchronous to clk.
*/
`timescale 1ns/10ps

module pps_pin_cell (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire pps_pkg::pps_sel_type sel,
  input wire logic panel_sig,
  input wire logic dflt_out,
  input wire logic dflt_oe,
  output logic pin_out_q,
  output logic pin_oe_q
);

  logic pin_out_d;
  logic pin_oe_d;

  // -----------------------------------------------------------------
  // Route the panel signal only on code 01; clr drives both low, other codes keep defaults.
  // -----------------------------------------------------------------
  always_comb begin
    pin_out_d = dflt_out;
    pin_oe_d = dflt_oe;
    if (clr) begin
      pin_out_d = 1'b0;
      pin_oe_d = 1'b0;
    end else if (sel == pps_pkg::SEL_PIN0) begin
      pin_out_d = panel_sig;
      pin_oe_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

endmodule

// ---- logic/pps_top.sv ----
/*
  Panel pin route block: one software register whose eleven selectors
  route display controller panel outputs onto package pins.
  Assumes a one-cycle register port master, a default pin control that
  supplies the pin levels while a panel signal is not routed, and a
  deep-standby reset that is a synchronous pulse on clk.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
// Notes on behaviour
// - Bits 25:24: timing signal 4 off at 00, on pin at 01.
// - Bits 23:22: timing signal 3 off at 00, on pin at 01.
// - Bits 21:20: timing signal 2 off at 00, on pin at 01.
// - Bits 19:18: timing signal 1 off at 00, on pin at 01.
// - Bits 17:16: timing signal 0 off at 00, on pin at 01.
// - Bits 11:10: line sync off at 00, on pin at 01.
// - Bits 9:8: frame sync off at 00, on pin at 01.
// - Bits 7:6: latch enable off at 00, on pin at 01.
// - Bits 5:4: data enable off at 00, on pin at 01.
// - Bits 3:2: dot clock off at 00, on pin at 01.
// - Bits 1:0: write enable off at 00, on pin at 01.
// - Bits 31:26 read zero; software writes zero there.
// - Bits 15:12 read zero; software writes zero there.
// - Reads return the stored fields and change nothing.
// - After reset every selector is 00, nothing routed.
// - Deep-standby reset leaves the register untouched.
`timescale 1ns/10ps
`include "pps_map.svh"

module pps_top #(
  parameter int NUM_SIG = `PPS_NUM_SIG
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dstby_rst,
  input wire pps_pkg::pps_bus_type bus,
  output logic [31:0] reg_rdata_q,
  input wire pps_pkg::pps_panel_type panel_in,
  input wire logic [NUM_SIG-1:0] dflt_out,
  input wire logic [NUM_SIG-1:0] dflt_oe,
  output logic [NUM_SIG-1:0] pin_out_q,
  output logic [NUM_SIG-1:0] pin_oe_q
);

  // -----------------------------------------------------------------
  // Parameter check.
  // -----------------------------------------------------------------
  if (NUM_SIG != `PPS_NUM_SIG) begin : g_bad_num
    $error("NUM_SIG must match the eleven selectors of the register.");
  end

  // -----------------------------------------------------------------
  // Field table, index 0 is write enable, index 10 timing signal 4.
  // -----------------------------------------------------------------
  localparam int FIELD_LSB [`PPS_NUM_SIG] = '{
    `PPS_PWE_LSB,
    `PPS_DCLK_LSB,
    `PPS_DEN_LSB,
    `PPS_LATCH_LSB,
    `PPS_FSYNC_LSB,
    `PPS_LSYNC_LSB,
    `PPS_TSIG0_LSB,
    `PPS_TSIG1_LSB,
    `PPS_TSIG2_LSB,
    `PPS_TSIG3_LSB,
    `PPS_TSIG4_LSB
  };

  logic hit;
  logic wr_hit;
  logic [31:0] route_q;
  logic [31:0] reg_rdata_d;
  logic [NUM_SIG-1:0] panel_vec;
  logic [NUM_SIG-1:0] routed;
  pps_pkg::pps_sel_type sel [NUM_SIG];

  // -----------------------------------------------------------------
  // Address decode; unmapped writes are dropped.
  // -----------------------------------------------------------------
  assign hit = (bus.addr == `PPS_ROUTE_OFS);
  assign wr_hit = bus.wr & hit;
  assign panel_vec = panel_in;

  pps_route_reg u_route (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_hit),
    .wdata(bus.wdata),
    .route_q(route_q)
  );

  // -----------------------------------------------------------------
  // Read data: one cycle after the strobe, zero otherwise.
  // -----------------------------------------------------------------
  always_comb begin
    reg_rdata_d = 32'h0000_0000;
    if (bus.rd && hit) begin
      reg_rdata_d = route_q & `PPS_ROUTE_MASK;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // -----------------------------------------------------------------
  // Checks clock and reset.
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // -----------------------------------------------------------------
  // One output stage per panel signal.
  // -----------------------------------------------------------------
  for (genvar i = 0; i < NUM_SIG; i++) begin : g_pin
    assign sel[i] = pps_pkg::pps_sel_type'(route_q[FIELD_LSB[i] +: 2]);
    assign routed[i] = (sel[i] == pps_pkg::SEL_PIN0);

    pps_pin_cell u_cell (
      .clk(clk),
      .sys_rst(sys_rst),
      .clr(dstby_rst),
      .sel(sel[i]),
      .panel_sig(panel_vec[i]),
      .dflt_out(dflt_out[i]),
      .dflt_oe(dflt_oe[i]),
      .pin_out_q(pin_out_q[i]),
      .pin_oe_q(pin_oe_q[i])
    );

    a_route_pin: assert property (
      sel[i] == pps_pkg::SEL_PIN0 && !dstby_rst
      |=> pin_oe_q[i] && pin_out_q[i] == $past(panel_vec[i])
    ) else $error("Selected panel signal not on its pin.");

    a_default_pin: assert property (
      sel[i] != pps_pkg::SEL_PIN0 && !dstby_rst
      |=> pin_out_q[i] == $past(dflt_out[i])
          && pin_oe_q[i] == $past(dflt_oe[i])
    ) else $error("Unrouted pin left default control.");
  end

  // -----------------------------------------------------------------
  // Field routing checks, one per selector.
  // -----------------------------------------------------------------
  a_timing4_route: assert property (
    route_q[`PPS_TSIG4_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[10]
        && pin_out_q[10] == $past(panel_in.timing_sig4_out)
  ) else $error("Timing signal 4 not on its pin.");

  a_timing3_route: assert property (
    route_q[`PPS_TSIG3_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[9]
        && pin_out_q[9] == $past(panel_in.timing_sig3_out)
  ) else $error("Timing signal 3 not on its pin.");

  a_timing2_route: assert property (
    route_q[`PPS_TSIG2_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[8]
        && pin_out_q[8] == $past(panel_in.timing_sig2_out)
  ) else $error("Timing signal 2 not on its pin.");

  a_timing1_route: assert property (
    route_q[`PPS_TSIG1_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[7]
        && pin_out_q[7] == $past(panel_in.timing_sig1_out)
  ) else $error("Timing signal 1 not on its pin.");

  a_timing0_route: assert property (
    route_q[`PPS_TSIG0_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[6]
        && pin_out_q[6] == $past(panel_in.timing_sig0_out)
  ) else $error("Timing signal 0 not on its pin.");

  a_line_sync_route: assert property (
    route_q[`PPS_LSYNC_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[5]
        && pin_out_q[5] == $past(panel_in.line_sync_out)
  ) else $error("Line sync not on its pin.");

  a_frame_sync_route: assert property (
    route_q[`PPS_FSYNC_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[4]
        && pin_out_q[4] == $past(panel_in.frame_sync_out)
  ) else $error("Frame sync not on its pin.");

  a_latch_route: assert property (
    route_q[`PPS_LATCH_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[3]
        && pin_out_q[3] == $past(panel_in.latch_enable_out)
  ) else $error("Latch enable not on its pin.");

  a_data_enable_route: assert property (
    route_q[`PPS_DEN_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[2]
        && pin_out_q[2] == $past(panel_in.data_enable_out)
  ) else $error("Data enable not on its pin.");

  a_dot_clock_route: assert property (
    route_q[`PPS_DCLK_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[1]
        && pin_out_q[1] == $past(panel_in.dot_clock_out)
  ) else $error("Dot clock not on its pin.");

  a_write_enable_route: assert property (
    route_q[`PPS_PWE_LSB +: 2] == 2'h1 && !dstby_rst
    |=> pin_oe_q[0]
        && pin_out_q[0] == $past(panel_in.write_enable_out)
  ) else $error("Write enable not on its pin.");

  // -----------------------------------------------------------------
  // Register port checks.
  // -----------------------------------------------------------------
  a_rsvd_hi_zero: assert property (
    reg_rdata_q[`PPS_RSVD_HI_MSB:`PPS_RSVD_HI_LSB] == 6'h00
    && route_q[`PPS_RSVD_HI_MSB:`PPS_RSVD_HI_LSB] == 6'h00
  ) else $error("Upper reserved bits not zero.");

  a_rsvd_mid_zero: assert property (
    reg_rdata_q[`PPS_RSVD_MID_MSB:`PPS_RSVD_MID_LSB] == 4'h0
    && route_q[`PPS_RSVD_MID_MSB:`PPS_RSVD_MID_LSB] == 4'h0
  ) else $error("Middle reserved bits not zero.");

  a_write_stores: assert property (
    wr_hit
    |=> route_q == ($past(bus.wdata) & `PPS_ROUTE_MASK)
  ) else $error("Write did not store the masked fields.");

  a_wr_unmapped: assert property (
    bus.wr && !hit
    |=> $stable(route_q)
  ) else $error("Unmapped write changed the route register.");

  a_write_read_back: assert property (
    wr_hit ##1 (bus.rd && hit && !bus.wr)
    |=> reg_rdata_q == ($past(bus.wdata, 2) & `PPS_ROUTE_MASK)
  ) else $error("Read did not return the written fields.");

  a_read_no_effect: assert property (
    bus.rd |=> $stable(route_q) && $stable(routed)
  ) else $error("Read changed the route register.");

  a_rdata_idle: assert property (
    !(bus.rd && hit) |=> reg_rdata_q == 32'h0000_0000
  ) else $error("Read data outside the answer cycle.");

  // -----------------------------------------------------------------
  // Reset checks.
  // -----------------------------------------------------------------
  a_reset_off: assert property (
    @(posedge clk) disable iff (1'b0)
    sys_rst |-> route_q == `PPS_ROUTE_RST && pin_oe_q == '0
  ) else $error("Selectors not cleared by reset.");

  // -----------------------------------------------------------------
  // Deep-standby checks.
  // -----------------------------------------------------------------
  a_dstby_keep: assert property (
    dstby_rst && !wr_hit |=> $stable(route_q)
  ) else $error("Deep-standby reset altered the register.");

  a_dstby_pins_off: assert property (
    dstby_rst
    |=> pin_oe_q == '0 && pin_out_q == '0
  ) else $error("Pins not released during deep-standby reset.");

  a_dstby_route_back: assert property (
    $fell(dstby_rst)
    |=> pin_oe_q == ($past(routed) | $past(dflt_oe))
  ) else $error("Routing lost across deep-standby reset.");

  // -----------------------------------------------------------------
  // Cover points.
  // -----------------------------------------------------------------
  c_route_on: cover property (
    wr_hit ##2 pin_oe_q[0]
  );

  c_read_back: cover property (
    wr_hit ##1 (bus.rd && hit) ##1 reg_rdata_q != 32'h0000_0000
  );

  c_bad_code: cover property (
    sel[10] == pps_pkg::SEL_BAD3
  );

  c_dstby_routed: cover property (
    dstby_rst && sel[5] == pps_pkg::SEL_PIN0
  );

  c_dstby_resume: cover property (
    $fell(dstby_rst) ##1 pin_oe_q[5]
  );

endmodule

// ---- verif/pps_panel_model.sv ----
/*
  Panel end of the eleven pin wires.
  Assumes a pull-down on every panel input, so an undriven wire reads low.
*/
`timescale 1ns/10ps

module pps_panel_model (
  input wire logic [10:0] pin_out,
  input wire logic [10:0] pin_oe,
  output logic [10:0] seen
);
  // A released wire falls to the pull-down level.
  assign seen = pin_oe & pin_out;
endmodule

// ---- verif/test_pps_top.sv ----
/*
  Self-checking bench of the panel pin route block.
  Assumes the register port and pin timing of the design's hand-over.
*/
`timescale 1ns/10ps

module test_pps_top;
  localparam logic [31:0] MASK = 32'h03ff_0fff;
  logic clk = 1'b0;
  logic sys_rst = 1'b0;
  logic dstby_rst = 1'b0;
  pps_pkg::pps_bus_type bus = '0;
  pps_pkg::pps_panel_type panel_in = '0;
  logic [10:0] dflt_out = 11'h2b5;
  logic [10:0] dflt_oe = 11'h4ca;
  logic [31:0] reg_rdata_q;
  logic [10:0] pin_out_q;
  logic [10:0] pin_oe_q;
  logic [10:0] seen;
  logic [15:0] rnd = 16'h0056;
  logic [31:0] model_q = '0;
  int miscompares = 0;
  int checks = 0;

  always #50 clk = ~clk;

  pps_top #(.NUM_SIG(11)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .dstby_rst(dstby_rst), .bus(bus), .reg_rdata_q(reg_rdata_q),
    .panel_in(panel_in), .dflt_out(dflt_out), .dflt_oe(dflt_oe),
    .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q));
  pps_panel_model panel_u (.pin_out(pin_out_q), .pin_oe(pin_oe_q),
    .seen(seen));

  // ---------------------------------------------------------------
  // Expectations.
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int lsb(int i);
    return (i < 6) ? 2 * i : 2 * i + 4;
  endfunction
  function automatic logic [10:0] exp_pin(logic [31:0] r,
      logic [10:0] on, logic [10:0] off);
    logic [10:0] v;
    for (int i = 0; i < 11; i++) begin
      v[i] = (r[lsb(i) +: 2] == 2'h1) ? on[i] : off[i];
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Checks and bus cycles.
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] sv, logic [31:0] ev);
    checks++;
    if (sv !== ev) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, ev, sv);
    end
  endtask

  task automatic pins(logic [10:0] eo, logic [10:0] ee);
    chk("pin out", {21'h0, pin_out_q}, {21'h0, eo});
    chk("pin oe", {21'h0, pin_oe_q}, {21'h0, ee});
    chk("panel level", {21'h0, seen}, {21'h0, eo & ee});
  endtask

  task automatic pins_now();
    pins(exp_pin(model_q, panel_in, dflt_out),
      exp_pin(model_q, 11'h7ff, dflt_oe));
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, bit keep);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    if (!keep) bus <= '0;
    if (a == 8'h00) model_q = d & MASK;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, bit now);
    if (!now) @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk("read data", reg_rdata_q, e);
  endtask

  task automatic route(logic [31:0] d);
    wr(8'h00, d, 1'b0);
    rnd = lfsr(rnd);
    panel_in <= rnd[10:0];
    rnd = lfsr(rnd);
    dflt_out <= rnd[10:0];
    rnd = lfsr(rnd);
    dflt_oe <= rnd[10:0];
    @(posedge clk);
    #1 pins_now();
    rd(8'h00, model_q, 1'b0);
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests.
  // ---------------------------------------------------------------
  initial begin
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 pins(dflt_out, dflt_oe);
    rd(8'h00, 32'h0, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin
      for (int c = 1; c < 4; c++) begin
        route(c << lsb(i));
      end
    end
    $display("test fields done");
    route(32'hffff_ffff);
    rd(8'h00, MASK, 1'b0);
    wr(8'h00, 32'h0155_0555, 1'b1);
    rd(8'h00, 32'h0155_0555, 1'b1);
    wr(8'h04, 32'h0, 1'b0);
    rd(8'h04, 32'h0, 1'b0);
    rd(8'h00, 32'h0155_0555, 1'b0);
    $display("test map done");
    repeat (40) begin
      rnd = lfsr(rnd);
      model_q[31:16] = rnd;
      rnd = lfsr(rnd);
      route({model_q[31:16], rnd});
    end
    $display("test random done");
    route(32'h0155_0555);
    @(posedge clk);
    dstby_rst <= 1'b1;
    @(posedge clk);
    #1 pins(11'h0, 11'h0);
    @(posedge clk);
    dstby_rst <= 1'b0;
    @(posedge clk);
    #1 pins_now();
    rd(8'h00, model_q, 1'b0);
    $display("test standby done");
    @(posedge clk);
    sys_rst <= 1'b1;
    #1 pins(11'h0, 11'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    model_q = '0;
    @(posedge clk);
    #1 pins_now();
    rd(8'h00, 32'h0, 1'b0);
    $display("test rerun reset done");
    final_report();
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    $display("ERROR watchdog expected finish seen hang");
    final_report();
  end
endmodule
